/* File: logic/tsseq_pkg.sv */
// Constants, register map and state encoding of the transfer sequencer.
// Assumes a 200 MHz pclk and 32-bit APB data.
package tsseq_pkg;
   localparam int          CLK_MHZ      = 200;
   localparam int          OVL_MAX_MS   = 100;
   localparam int          OVL_CYC      = OVL_MAX_MS * 1000 * CLK_MHZ;
   localparam int          DLY_W        = 16;
   localparam int          NUM_DLY      = 5;
   localparam int          NUM_EVT      = 4;

   localparam logic [7:0]  ADDR_CTRL    = 8'h00;
   localparam logic [7:0]  ADDR_PRESC   = 8'h04;
   localparam logic [7:0]  ADDR_DLY0    = 8'h08;
   localparam logic [7:0]  ADDR_STATUS  = 8'h1c;
   localparam logic [7:0]  ADDR_INT_ST  = 8'h20;
   localparam logic [7:0]  ADDR_INT_CLR = 8'h24;
   localparam logic [7:0]  ADDR_INT_EN  = 8'h28;

   localparam int          CTRL_TEST    = 0;
   localparam int          CTRL_DWELL   = 1;
   localparam logic [1:0]  CTRL_RST     = 2'h0;
   localparam logic [15:0] PRESC_RST    = 16'hffff;
   localparam logic [15:0] DLY_RST      = 16'h000a;

   // Delay indices
   localparam int          D_START      = 0;
   localparam int          D_N2E        = 1;
   localparam int          D_DWELL      = 2;
   localparam int          D_E2N        = 3;
   localparam int          D_COOL       = 4;

   // Event bits
   localparam int          EV_S1_LOST   = 0;
   localparam int          EV_GEN_START = 1;
   localparam int          EV_ON_S2     = 2;
   localparam int          EV_ON_S1     = 3;

   typedef enum logic [3:0] {
      ST_ON_S1    = 4'b0000,
      ST_ES_WAIT  = 4'b0001,
      ST_GEN_WAIT = 4'b0011,
      ST_NE_WAIT  = 4'b0010,
      ST_NEUT_S2  = 4'b0110,
      ST_ON_S2    = 4'b0111,
      ST_EN_WAIT  = 4'b0101,
      ST_OVL_S1   = 4'b0100,
      ST_COOL     = 4'b1100,
      ST_OVL_S2   = 4'b1101,
      ST_NEUT_S1  = 4'b1111
   } tsseq_state_t;
endpackage

/* File: logic/tsseq_tmr_if.sv */
// Link between the sequencer and its shared delay timer.
// Assumes both ends run on the same pclk.
`timescale 1ns/10ps
interface tsseq_tmr_if;
   import tsseq_pkg::*;
   logic             ce;
   logic             tick;
   logic             run;
   logic             clr;
   logic [DLY_W-1:0] dur;
   logic             done;
   modport seq (output ce, output tick, output run, output clr,
                output dur, input done);
   modport tmr (input ce, input tick, input run, input clr,
                input dur, output done);
endinterface

/* File: logic/tsseq_timer.sv */
// Delay timer counting prescaled ticks up to a chosen duration.
// Assumes clr pulses when a new delay begins.
`timescale 1ns/10ps
module tsseq_timer (
   input  wire logic pclk,
   input  wire logic presetn,
   tsseq_tmr_if.tmr  tif
);
   import tsseq_pkg::*;

   logic [DLY_W-1:0] cnt_r;
   logic             done_r;

   assign tif.done = done_r;

   // Dropped run or a restart cancels the delay (see RQ13)
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r  <= '0;
         done_r <= 1'b0;
      end else if (tif.ce) begin
         if (tif.clr || !tif.run) begin
            cnt_r  <= '0;
            done_r <= 1'b0;
         end else if (cnt_r >= tif.dur) begin
            done_r <= 1'b1;
         end else if (tif.tick) begin
            cnt_r <= cnt_r + 1'b1;
         end
      end
   end
endmodule

/* File: logic/tsseq_top.sv */
// Transfer switch sequencer: source watch, delays, contacts, lamps, APB.
// Assumes source status pins are asynchronous and APB runs on pclk.
`timescale 1ns/10ps
// What this block does
// RQ1 - A transfer involving an out-of-spec source opens the old contacts before closing the new.
// RQ2 - A transfer between two live synchronized sources closes the new contacts before opening the old.
// RQ3 - Loss of source one starts the engine-start delay and darkens the source one available lamp.
// RQ4 - When the engine-start delay expires with source one still bad the generator start is raised.
// RQ5 - Generator pickup lights its availability lamp and starts the normal-to-emergency delay.
// RQ6 - At the end of that delay the switch goes to neutral and the source one connected lamp goes out.
// RQ7 - With dwell enabled the switch waits the neutral dwell, then closes onto source two and lights its lamp.
// RQ8 - Source one returning while on source two lights its lamp and starts the emergency-to-normal delay.
// RQ9 - After that delay the retransfer is closed when in sync, otherwise open.
// RQ10 - A closed retransfer closes source one first and opens source two within the overlap limit.
// RQ11 - After retransfer the cool-down delay runs, then the generator start and its lamp drop.
// RQ12 - In test mode the transfer is closed when in sync, and the retransfer waits until test mode is cleared.
// RQ13 - Every delay counts prescaled ticks to a set length and is cancelled when its cause goes away.
module tsseq_top #(
   parameter int OVL_LIMIT = tsseq_pkg::OVL_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        src1_ok,
   input  wire logic        src2_pickup,
   input  wire logic        src_sync,
   output logic             gen_start,
   output logic             s1_close,
   output logic             s2_close,
   output logic             s1_avail_lamp,
   output logic             s2_avail_lamp,
   output logic             s1_conn_lamp,
   output logic             s2_conn_lamp,
   output logic             irq
);
   import tsseq_pkg::*;

   tsseq_tmr_if tif ();

   logic [1:0]               s1_sy_r;
   logic [1:0]               s2_sy_r;
   logic [1:0]               sy_sy_r;
   logic [1:0]               ctrl_r;
   logic [15:0]              presc_r;
   logic [15:0]              pcnt_r;
   logic                     tick_r;
   logic [DLY_W-1:0]         dly_r [NUM_DLY];
   logic [NUM_EVT-1:0]       ist_r;
   logic [NUM_EVT-1:0]       ien_r;
   logic [NUM_EVT-1:0]       evt;
   tsseq_state_t             state_r;
   tsseq_state_t             state_nxt;
   logic [31:0]              ovl_r;
   logic                     s1_ok;
   logic                     s2_ok;
   logic                     in_sync;
   logic                     acc;
   logic                     wr;
   logic                     mapped;
   logic [31:0]              rdata;

   // Two-flop synchronisers on the source pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_sy_r <= 2'h0;
         s2_sy_r <= 2'h0;
         sy_sy_r <= 2'h0;
      end else if (ce) begin
         s1_sy_r <= {s1_sy_r[0], src1_ok};
         s2_sy_r <= {s2_sy_r[0], src2_pickup};
         sy_sy_r <= {sy_sy_r[0], src_sync};
      end
   end

   assign s1_ok   = s1_sy_r[1];
   assign s2_ok   = s2_sy_r[1];
   assign in_sync = sy_sy_r[1];

   // Prescaler giving the delay tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pcnt_r <= 16'h0;
         tick_r <= 1'b0;
      end else if (ce) begin
         tick_r <= (pcnt_r >= presc_r);
         if (pcnt_r >= presc_r) begin
            pcnt_r <= 16'h0;
         end else begin
            pcnt_r <= pcnt_r + 16'h1;
         end
      end
   end

   // Next state of the transfer sequence
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_ON_S1: begin
            if (!s1_ok) begin
               state_nxt = ST_ES_WAIT;                    // see RQ3
            end else if (ctrl_r[CTRL_TEST]) begin
               state_nxt = ST_GEN_WAIT;
            end
         end
         ST_ES_WAIT: begin
            if (s1_ok) begin
               state_nxt = ST_ON_S1;                      // see RQ13
            end else if (tif.done) begin
               state_nxt = ST_GEN_WAIT;                   // see RQ4
            end
         end
         ST_GEN_WAIT: begin
            if (s1_ok && !ctrl_r[CTRL_TEST]) begin
               state_nxt = ST_COOL;
            end else if (s2_ok) begin
               state_nxt = ST_NE_WAIT;                    // see RQ5
            end
         end
         ST_NE_WAIT: begin
            if (!s2_ok) begin
               state_nxt = ST_GEN_WAIT;                   // see RQ13
            end else if (s1_ok && !ctrl_r[CTRL_TEST]) begin
               state_nxt = ST_COOL;
            end else if (tif.done) begin
               if (s1_ok && in_sync) begin
                  state_nxt = ST_OVL_S2;                  // see RQ2
               end else begin
                  state_nxt = ST_NEUT_S2;                 // see RQ1
               end
            end
         end
         ST_NEUT_S2: begin
            if (!ctrl_r[CTRL_DWELL] || tif.done) begin
               state_nxt = ST_ON_S2;                      // see RQ7
            end
         end
         ST_OVL_S2: begin
            if (ovl_r >= 32'(OVL_LIMIT - 1)) begin
               state_nxt = ST_ON_S2;                      // see RQ12
            end
         end
         ST_ON_S2: begin
            if (s1_ok && !ctrl_r[CTRL_TEST]) begin
               state_nxt = ST_EN_WAIT;                    // see RQ8
            end
         end
         ST_EN_WAIT: begin
            if (!s1_ok) begin
               state_nxt = ST_ON_S2;                      // see RQ13
            end else if (tif.done) begin
               if (s2_ok && in_sync) begin
                  state_nxt = ST_OVL_S1;                  // see RQ9
               end else begin
                  state_nxt = ST_NEUT_S1;                 // see RQ1
               end
            end
         end
         ST_OVL_S1: begin
            if (ovl_r >= 32'(OVL_LIMIT - 1)) begin
               state_nxt = ST_COOL;                       // see RQ10
            end
         end
         ST_NEUT_S1: begin
            if (!ctrl_r[CTRL_DWELL] || tif.done) begin
               state_nxt = ST_COOL;
            end
         end
         ST_COOL: begin
            if (!s1_ok) begin
               state_nxt = ST_GEN_WAIT;                   // see RQ13
            end else if (tif.done) begin
               state_nxt = ST_ON_S1;                      // see RQ11
            end
         end
         default: begin
            state_nxt = ST_ON_S1;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_ON_S1;
      end else if (ce) begin
         state_r <= state_nxt;
      end
   end

   // Overlap counter bounding the time both contacts are closed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovl_r <= 32'h0;
      end else if (ce) begin
         if (state_r == ST_OVL_S1 || state_r == ST_OVL_S2) begin
            ovl_r <= ovl_r + 32'h1;                       // see RQ10
         end else begin
            ovl_r <= 32'h0;
         end
      end
   end

   // Shared delay timer, restarted on every state change
   assign tif.ce   = ce;
   assign tif.tick = tick_r;
   assign tif.clr  = (state_nxt != state_r);
   always_comb begin
      tif.run = 1'b1;
      tif.dur = dly_r[D_START];
      case (state_r)
         ST_ES_WAIT:  tif.dur = dly_r[D_START];           // see RQ3
         ST_NE_WAIT:  tif.dur = dly_r[D_N2E];             // see RQ5
         ST_NEUT_S2:  tif.dur = dly_r[D_DWELL];           // see RQ7
         ST_NEUT_S1:  tif.dur = dly_r[D_DWELL];
         ST_EN_WAIT:  tif.dur = dly_r[D_E2N];             // see RQ8
         ST_COOL:     tif.dur = dly_r[D_COOL];            // see RQ11
         default:     tif.run = 1'b0;
      endcase
   end

   tsseq_timer u_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .tif     (tif.tmr)
   );

   // Contacts and generator start from the next state, lamps from contacts and sources
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_close      <= 1'b0;
         s2_close      <= 1'b0;
         gen_start     <= 1'b0;
         s1_conn_lamp  <= 1'b0;
         s2_conn_lamp  <= 1'b0;
         s1_avail_lamp <= 1'b0;
         s2_avail_lamp <= 1'b0;
      end else if (ce) begin
         s1_close <= (state_nxt == ST_ON_S1)   ||
                     (state_nxt == ST_ES_WAIT) ||
                     (state_nxt == ST_GEN_WAIT)||
                     (state_nxt == ST_NE_WAIT) ||
                     (state_nxt == ST_OVL_S2)  ||
                     (state_nxt == ST_OVL_S1)  ||
                     (state_nxt == ST_COOL);              // see RQ6
         s2_close <= (state_nxt == ST_ON_S2)   ||
                     (state_nxt == ST_EN_WAIT) ||
                     (state_nxt == ST_OVL_S2)  ||
                     (state_nxt == ST_OVL_S1);            // see RQ10
         s1_conn_lamp <= s1_close;
         s2_conn_lamp <= s2_close;
         gen_start <= !(state_nxt == ST_ON_S1 ||
                        state_nxt == ST_ES_WAIT);         // see RQ4
         s1_avail_lamp <= s1_ok;                          // see RQ3
         s2_avail_lamp <= s2_ok && gen_start;             // see RQ5
      end
   end

   // Sequence events
   assign evt[EV_S1_LOST]   = (state_r == ST_ON_S1) &&
                              (state_nxt == ST_ES_WAIT);
   assign evt[EV_GEN_START] = (state_nxt == ST_GEN_WAIT) &&
                              (state_r == ST_ES_WAIT ||
                               state_r == ST_ON_S1);
   assign evt[EV_ON_S2]     = (state_nxt == ST_ON_S2) &&
                              (state_r == ST_NEUT_S2 ||
                               state_r == ST_OVL_S2);
   assign evt[EV_ON_S1]     = (state_nxt == ST_COOL) &&
                              (state_r == ST_OVL_S1 ||
                               state_r == ST_NEUT_S1);

   // APB decode
   assign acc    = psel && penable && !pready;
   assign wr     = acc && pwrite;
   assign mapped = (paddr[1:0] == 2'h0) && (paddr <= ADDR_INT_EN);

   // Control, prescale and delay registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r  <= CTRL_RST;
         presc_r <= PRESC_RST;
         ien_r   <= '0;
         for (int i = 0; i < NUM_DLY; i++) begin
            dly_r[i] <= DLY_RST;
         end
      end else if (ce && wr) begin
         if (paddr == ADDR_CTRL) begin
            ctrl_r <= pwdata[1:0];
         end
         if (paddr == ADDR_PRESC) begin
            presc_r <= pwdata[15:0];
         end
         if (paddr == ADDR_INT_EN) begin
            ien_r <= pwdata[NUM_EVT-1:0];
         end
         for (int i = 0; i < NUM_DLY; i++) begin
            if (paddr == ADDR_DLY0 + 8'(4 * i)) begin
               dly_r[i] <= pwdata[DLY_W-1:0];             // see RQ13
            end
         end
      end
   end

   // Sticky event bits; a new event wins over a clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ist_r <= '0;
      end else if (ce) begin
         if (wr && paddr == ADDR_INT_CLR) begin
            ist_r <= (ist_r & ~pwdata[NUM_EVT-1:0]) | evt;
         end else begin
            ist_r <= ist_r | evt;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else if (ce) begin
         irq <= |(ist_r & ien_r);
      end
   end

   // Read mux
   always_comb begin
      rdata = 32'h0;
      case (paddr)
         ADDR_CTRL:    rdata = {30'h0, ctrl_r};
         ADDR_PRESC:   rdata = {16'h0, presc_r};
         ADDR_STATUS:  rdata = {22'h0, in_sync, s2_ok, s1_ok,
                                gen_start, s2_close, s1_close,
                                state_r};
         ADDR_INT_ST:  rdata = {28'h0, ist_r};
         ADDR_INT_EN:  rdata = {28'h0, ien_r};
         default: begin
            for (int i = 0; i < NUM_DLY; i++) begin
               if (paddr == ADDR_DLY0 + 8'(4 * i)) begin
                  rdata = {16'h0, dly_r[i]};
               end
            end
         end
      endcase
   end

   // One wait state, then a registered answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else if (ce) begin
         pready  <= acc;
         pslverr <= acc && !mapped;
         if (acc && !pwrite) begin
            prdata <= mapped ? rdata : 32'h0;
         end
      end
   end
endmodule

/* File: verif/tsseq_monitor.sv */
// Port checker for the transfer sequencer, bound onto its top module.
// Assumes ce stays high while the source inputs change.
`timescale 1ns/10ps
module tsseq_monitor #(
   parameter int OVL_LIMIT = 8
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        ce,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        src1_ok,
   input wire logic        src_sync,
   input wire logic        gen_start,
   input wire logic        s1_close,
   input wire logic        s2_close,
   input wire logic        s1_avail_lamp,
   input wire logic        s2_avail_lamp,
   input wire logic        s1_conn_lamp,
   input wire logic        s2_conn_lamp
);
   int ovl_cnt;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Cycles with both sources on the load
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovl_cnt <= 0;
      end else begin
         ovl_cnt <= (s1_close && s2_close) ? ovl_cnt + 1 : 0;
      end
   end
   overlap_bound_a: assert property (ovl_cnt <= OVL_LIMIT + 1)
      else $error("parallel period too long");
   closed_needs_sync_a: assert property (
      $rose(s1_close && s2_close) |-> $past(src_sync, 3) && $past(src1_ok, 3))
      else $error("paralleled without sync");
   open_to_s2_a: assert property (
      ($rose(s2_close) && !s1_close) |-> !$past(s1_close))
      else $error("source two closed without neutral");
   open_to_s1_a: assert property (
      ($rose(s1_close) && !s2_close) |-> !$past(s2_close))
      else $error("source one closed without neutral");
   lamp_order_a: assert property (
      ($rose(s1_close) && s2_close) |=> s1_conn_lamp && s2_conn_lamp)
      else $error("connected lamps out of order");
   gen_stop_s1_a: assert property (
      $fell(gen_start) |-> s1_close && !s2_close)
      else $error("generator stopped off source one");
   s1_lamp_loss_a: assert property (
      $fell(s1_avail_lamp) |-> !$past(src1_ok, 3))
      else $error("source one lamp dropped while healthy");
   s2_lamp_gen_a: assert property (
      s2_avail_lamp |-> $past(gen_start))
      else $error("source two lamp without start");
   answer_next_a: assert property (
      (psel && penable && !pready && ce) |=> pready)
      else $error("bus answer late");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   err_ready_a: assert property (
      pslverr |-> pready && (pwrite || prdata == 32'h0))
      else $error("bad error response");
endmodule

bind tsseq_top tsseq_monitor #(.OVL_LIMIT(OVL_LIMIT)) mon_u (
   .pclk, .presetn, .ce, .psel, .penable, .pwrite, .prdata, .pready,
   .pslverr, .src1_ok, .src_sync, .gen_start, .s1_close, .s2_close,
   .s1_avail_lamp, .s2_avail_lamp, .s1_conn_lamp, .s2_conn_lamp
);

/* File: verif/tsseq_gen_model.sv */
// Generator set model: pickup follows the start request after a ramp.
// Assumes the bench picks a prompt or a slow ramp through slow.
`timescale 1ns/10ps
module tsseq_gen_model (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic gen_start,
   input  wire logic slow,
   output logic      src2_pickup
);
   int ramp_cnt;
   // Output collapses as soon as the start request goes away
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ramp_cnt    <= 0;
         src2_pickup <= 1'b0;
      end else if (!gen_start) begin
         ramp_cnt    <= 0;
         src2_pickup <= 1'b0;
      end else if (ramp_cnt >= (slow ? 40 : 3)) begin
         src2_pickup <= 1'b1;
      end else begin
         ramp_cnt <= ramp_cnt + 1;
      end
   end
endmodule

/* File: verif/tb.sv */
// Self-checking bench of the transfer sequencer with a generator model.
// Assumes a 200 MHz pclk and a shortened paralleling limit.
`timescale 1ns/10ps
module tb;
   import tsseq_pkg::*;
   localparam int OVL = 8;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        ce = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, er, irq;
   logic        slow = 1'b0;
   logic        src1_ok = 1'b1;
   logic        src_sync = 1'b0;
   logic        src2_pickup, gen_start, s1_close, s2_close;
   logic        s1_avail_lamp, s2_avail_lamp, s1_conn_lamp, s2_conn_lamp;
   logic [31:0] seed = 32'hac1d0b2e;
   logic [15:0] dly [5];
   int          err_total = 0;
   int          num_checks = 0;
   int          c;

   always #2.5 pclk = ~pclk;

   tsseq_top #(.OVL_LIMIT(OVL)) dut_u (
      .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .src1_ok, .src2_pickup, .src_sync,
      .gen_start, .s1_close, .s2_close, .s1_avail_lamp, .s2_avail_lamp,
      .s1_conn_lamp, .s2_conn_lamp, .irq
   );
   tsseq_gen_model gen_u (.pclk, .presetn, .gen_start, .slow, .src2_pickup);

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task test_done;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task give_up(input string nm);
      err_total++;
      $display("[ERR] %s expected done seen timeout", nm);
      test_done();
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) give_up("apb");
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wt(ref logic s, input logic v, output int n);
      n = 0;
      while (s !== v) begin
         @(posedge pclk);
         n++;
         if (n > 2000) give_up("wait");
      end
   endtask

   // One outage and return of source one
   task automatic outage(input logic syn);
      src_sync <= syn;
      slow     <= !syn;
      src1_ok  <= 1'b0;
      wt(gen_start, 1'b1, c);
      chk("start_dly", c >= dly[D_START], 1);
      chk("s1_held", s1_close, 1);
      wt(s1_close, 1'b0, c);
      chk("s2_lamp", s2_avail_lamp, 1);
      wt(s2_close, 1'b1, c);
      chk("dwell", c >= dly[D_DWELL], 1);
      chk("open_s2", s1_close, 0);
      @(posedge pclk);
      chk("s2_conn", {s1_conn_lamp, s2_conn_lamp}, 2'b01);
      apb(0, ADDR_INT_ST, 0);
      chk("int_st", rd, 32'h7);
      chk("irq_on", irq, 1);
      apb(1, ADDR_INT_CLR, 32'hf);
      apb(0, ADDR_INT_ST, 0);
      chk("int_clr", {rd[3:0], irq}, 5'h0);
      src1_ok <= 1'b1;
      wt(s1_avail_lamp, 1'b1, c);
      chk("still_s2", s2_close, 1);
      wt(s1_close, 1'b1, c);
      chk("en_dly", c >= dly[D_E2N], 1);
      chk("closed", s2_close, syn);
      wt(s2_close, 1'b0, c);
      chk("overlap", c <= OVL + 1, 1);
      wt(gen_start, 1'b0, c);
      chk("cool", c >= dly[D_COOL], 1);
      repeat (3) @(posedge pclk);
      chk("s2_lamp_off", s2_avail_lamp, 0);
      apb(0, ADDR_INT_ST, 0);
      chk("int_back", rd, 32'h8);
      apb(1, ADDR_INT_CLR, 32'hf);
   endtask

   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         apb(0, ADDR_DLY0 + 8'(4 * i), 0);
         chk("dly_rst", rd, {16'h0, DLY_RST});
      end
      apb(0, ADDR_PRESC, 0);
      chk("presc_rst", rd, {16'h0, PRESC_RST});
      apb(0, 8'h30, 0);
      chk("unmapped_err", er, 1);
      chk("unmapped", rd, 32'h0);
      apb(1, 8'h02, 32'h3);
      chk("unaligned", er, 1);
      apb(1, ADDR_PRESC, 0);
      for (int i = 0; i < 5; i++) begin
         seed   = lfsr(seed);
         dly[i] = 16'h4 + 16'(seed[2:0]);
         apb(1, ADDR_DLY0 + 8'(4 * i), {16'h0, dly[i]});
      end
      apb(1, ADDR_INT_EN, 32'hf);
      apb(1, ADDR_CTRL, 32'h2);
      // Short dip: delay must be cancelled
      src1_ok <= 1'b0;
      repeat (2) @(posedge pclk);
      src1_ok <= 1'b1;
      wt(s1_avail_lamp, 1'b0, c);
      chk("dip_seen", c < 10, 1);
      repeat (60) @(posedge pclk);
      chk("no_start", {gen_start, s1_close}, 2'b01);
      apb(1, ADDR_INT_CLR, 32'hf);
      outage(1'b1);
      outage(1'b0);
      // Test run: closed both ways
      src_sync <= 1'b1;
      apb(1, ADDR_CTRL, 32'h3);
      wt(s2_close, 1'b1, c);
      chk("test_to_s2", s1_close, 1);
      wt(s1_close, 1'b0, c);
      apb(1, ADDR_CTRL, 32'h2);
      wt(s1_close, 1'b1, c);
      chk("test_to_s1", s2_close, 1);
      wt(gen_start, 1'b0, c);
      // Clock enable low: a source loss must not be seen
      ce      <= 1'b0;
      src1_ok <= 1'b0;
      repeat (10) @(posedge pclk);
      chk("ce_hold", {gen_start, s1_avail_lamp, s1_close}, 3'b011);
      ce      <= 1'b1;
      src1_ok <= 1'b1;
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, ADDR_PRESC, 0);
      chk("re_reset_s1", s1_close, 1);
      chk("re_reset", rd, {16'h0, PRESC_RST});
      apb(0, ADDR_STATUS, 0);
      chk("status", rd, 32'h290);
      test_done();
   end
endmodule
